// ### bench/madp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module madp_mem_model (
    input  wire logic        clk_i,        // system clock
    input  wire logic [12:1] addr_i,       // address register
    input  wire logic        wr_i,         // erasable write strobe
    input  wire logic [16:1] wword_i,      // word being written
    input  wire logic        wpar_i,       // generated parity line
    input  wire logic        rd_i,         // read request from bench
    input  wire logic        bad_i,        // flip stored parity on this read
    output logic      [16:1] read_word_o,  // word to parity checker
    output logic             stored_par_o, // parity bit from memory
    output logic             readout_o     // one-cycle readout strobe
);
    logic [16:1] mem [0:15];
    logic [16:1] pend_q;
    logic [3:0]  pidx_q;
    logic        pwr_q;
    wire  logic [16:1] cur = mem[addr_i[4:1]];

    initial begin
        read_word_o = 16'h0000;
        stored_par_o = 1'b0;
        readout_o = 1'b0;
        pwr_q = 1'b0;
        pend_q = 16'h0000;
        pidx_q = 4'h0;
    end

    always @(posedge clk_i) begin
        pwr_q <= wr_i;
        if (wr_i) begin
            pend_q <= wword_i;
            pidx_q <= addr_i[4:1];
        end
        // the parity line is only valid one cycle after the strobe
        if (pwr_q) mem[pidx_q] <= {pend_q[16], wpar_i, pend_q[14:1]};
        readout_o <= rd_i;
        if (rd_i) begin
            // bit 15 on the data lines is junk; parity travels on its own line
            read_word_o <= {cur[16], ~cur[15], cur[14:1]};
            stored_par_o <= cur[15] ^ bad_i;
        end else begin
            // released lines wander so a stale word never looks valid
            read_word_o <= ~read_word_o;
            stored_par_o <= ~stored_par_o;
        end
    end
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [3:0]  sel = 4'h0;
    logic        ack, ctl = 1'b0, tim = 1'b0, ewr = 1'b0, rdq = 1'b0, bad = 1'b0;
    logic [16:1] wl = 16'h0000, ww = 16'h0000, rword;
    logic        spar, rdo, alarm, pline;
    logic [7:0]  xl, xh, yh;
    logic [3:0]  yl;
    logic [5:0]  fs, fsn;
    logic [4:0]  cg;
    logic [12:1] areg;
    logic [2:0]  eb = 3'h0, fe = 3'h0;
    logic [4:0]  fb = 5'h00;
    int miscompares = 0, checks_done = 0, cycles = 0;

    madp_top i_dut (.CLK_I(clk), .SYS_RST_I(rst), .ADR_I(adr), .DAT_I(dat), .SEL_I(sel),
        .WE_I(we), .CYC_I(cyc), .STB_I(stb), .DAT_O(dat_o), .ACK_O(ack),
        .WRITE_LINES_I(wl), .ADDRESS_WRITE_CONTROL_I(ctl), .WRITE_TIMING_I(tim),
        .READ_WORD_I(rword), .STORED_PARITY_BIT_I(spar), .READOUT_I(rdo),
        .WRITE_WORD_I(ww), .ERASABLE_WRITE_I(ewr), .X_LOW_SELECT_O(xl),
        .X_HIGH_SELECT_O(xh), .Y_LOW_SELECT_O(yl), .Y_HIGH_SELECT_O(yh),
        .FIXED_SELECT_O(fs), .FIXED_SELECT_N_O(fsn), .COUNTER_GROUP_O(cg),
        .PARITY_ALARM_O(alarm), .PARITY_WRITE_LINE_O(pline), .ADDRESS_REG_O(areg));
    madp_mem_model i_mem (.clk_i(clk), .addr_i(areg), .wr_i(ewr), .wword_i(ww),
        .wpar_i(pline), .rd_i(rdq), .bad_i(bad), .read_word_o(rword),
        .stored_par_o(spar), .readout_o(rdo));

    initial forever #50 clk = ~clk;

    task automatic give_verdict();
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        q = dat_o;
        // one wait state: ack is seen at the second edge after the request
        chk("wb ack edges", 32'h2, n);
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic ld(input logic [12:1] a, input logic c, input logic t);
        @(posedge clk);
        wl <= {4'hA, a}; ctl <= c; tim <= t;
        @(posedge clk);
        ctl <= 1'b0; tim <= 1'b0; wl <= 16'h5A5A;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic set_banks(input logic [2:0] e, input logic [4:0] f, input logic [2:0] x);
        eb = e; fb = f; fe = x;
        wb(1'b1, madp_pkg::OFS_ERASABLE_BANK_REG, {29'h0, e}, 4'hF);
        wb(1'b1, madp_pkg::OFS_FIXED_BANK_REG, {27'h0, f}, 4'hF);
        wb(1'b1, madp_pkg::OFS_FIXED_EXTENSION_REG, {29'h0, x}, 4'hF);
    endtask

    task automatic decode(input logic [12:1] a);
        logic [2:0] y;
        logic [4:0] g;
        logic [5:0] f;
        ld(a, 1'b1, 1'b1);
        y = (a[10:9] == 2'h3) ? eb : {1'b0, a[10:9]};
        g = 5'h00;
        if (a[12:11] == 2'h0 && y == 3'h0 && a[8:7] == 2'h0 && a[6:4] >= 3'h2 && a[6:4] <= 3'h6)
            g = 5'h01 << (a[6:4] - 3'h2);
        case (a[12:11])
            2'h1: f = {fb[4:3] == 2'h3 && fe >= 3'h4, fb};
            2'h2: f = 6'h02;
            2'h3: f = 6'h03;
            default: f = 6'h00;
        endcase
        chk("address reg", a, areg);
        chk("x low", 8'h01 << a[3:1], xl);
        chk("x high", 8'h01 << a[6:4], xh);
        chk("y low", 4'h1 << a[8:7], yl);
        chk("y high", 8'h01 << y, yh);
        chk("counter group", g, cg);
        chk("fixed", f, fs);
        chk("fixed n", {26'h0, ~f}, fsn);
    endtask

    task automatic t_regs();
        chk("x low rst", 8'h01, xl);
        chk("fixed n rst", 6'h3F, fsn);
        wb(1'b0, madp_pkg::OFS_STATUS, 32'h0, 4'hF);
        chk("status rst", 32'h0, q);
        set_banks(3'h5, 5'h1B, 3'h4);
        wb(1'b1, madp_pkg::OFS_ERASABLE_BANK_REG, 32'h2, 4'hE);
        wb(1'b1, 8'h10, 32'h7, 4'hF);
        wb(1'b0, 8'h10, 32'h0, 4'hF);
        chk("unmapped", 32'h0, q);
        wb(1'b0, madp_pkg::OFS_ERASABLE_BANK_REG, 32'h0, 4'hF);
        chk("erasable_bank_reg", 32'h5, q);
        wb(1'b0, madp_pkg::OFS_FIXED_BANK_REG, 32'h0, 4'hF);
        chk("fixed_bank_reg", 32'h1B, q);
    endtask

    task automatic t_decode();
        logic [12:1] tbl [12] = '{12'h000, 12'h00F, 12'h010, 12'h017, 12'h037, 12'h038,
            12'h0FF, 12'h100, 12'h300, 12'h400, 12'h800, 12'hC00};
        foreach (tbl[i]) decode(tbl[i]);
        set_banks(3'h0, 5'h07, 3'h3);
        decode(12'h301);
        decode(12'h5AB);
        ld(12'h123, 1'b1, 1'b0);
        chk("no load ctl", 12'h5AB, areg);
        ld(12'h123, 1'b0, 1'b1);
        chk("no load tim", 12'h5AB, areg);
    endtask

    task automatic rd_cnt(input logic b, output int n);
        n = 0;
        @(posedge clk);
        rdq <= 1'b1; bad <= b;
        @(posedge clk);
        rdq <= 1'b0; bad <= 1'b0;
        repeat (8) begin
            @(posedge clk);
            #1;
            if (alarm === 1'b1) n++;
        end
    endtask

    task automatic t_parity();
        logic [16:1] wt [5] = '{16'h0000, 16'hFFFF, 16'h0001, 16'h4003, 16'h8000};
        int n;
        ld(12'h005, 1'b1, 1'b1);
        foreach (wt[i]) begin
            @(posedge clk);
            ewr <= 1'b1; ww <= wt[i];
            @(posedge clk);
            ewr <= 1'b0; ww <= ~wt[i];
            #1;
            chk("parity line", ~^{wt[i][16], wt[i][14:1]}, pline);
            rd_cnt(1'b0, n);
            chk("good read", 32'h0, n);
            rd_cnt(1'b1, n);
            chk("bad read", 32'h1, n);
        end
        wb(1'b0, madp_pkg::OFS_STATUS, 32'h0, 4'hF);
        chk("status", {18'h0, 1'b0, 1'b1, 12'h005}, q);
        wb(1'b1, madp_pkg::OFS_STATUS, 32'h1000, 4'h2);
        wb(1'b0, madp_pkg::OFS_STATUS, 32'h0, 4'hF);
        chk("status clr", 32'h5, q);
        n = 0;
        repeat (30) begin
            @(posedge clk);
            #1;
            if (alarm === 1'b1) n++;
        end
        chk("idle alarm", 32'h0, n);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_regs();
        t_decode();
        t_parity();
        give_verdict();
    end
endmodule
`default_nettype wire

// ### verilog/madp_onehot.sv
`timescale 1ns/1ps
`default_nettype none
module madp_onehot #(
    parameter int IDX_W = 3
) (
    input  wire logic [IDX_W-1:0]      idx_i,   // binary index
    output wire logic [(1<<IDX_W)-1:0] lines_o  // one line per index value
);
    genvar i;
    generate
        for (i = 0; i < (1 << IDX_W); i++) begin : g_line
            // exactly one compare matches any index value
            assign lines_o[i] = (idx_i == IDX_W'(i)); // [R21]
        end
    endgenerate
endmodule
`default_nettype wire

// ### verilog/madp_parity.sv
`timescale 1ns/1ps
`default_nettype none
module madp_parity (
    input  wire logic [16:1] word_i,    // memory word, bit 15 ignored
    output wire logic [5:1]  group_o,   // parity_group_1 .. parity_group_5
    output wire logic [5:1]  group_n_o, // complements of the groups
    output wire logic        tree_o,    // one when data bits hold odd ones
    output wire logic        tree_n_o   // inverted tree output
);
    logic [15:1] data15;

    // bit 15 is the parity bit itself and is left out of the check
    assign data15 = {word_i[16], word_i[14:1]}; // [R13]

    genvar g;
    generate
        for (g = 1; g <= 5; g++) begin : g_grp
            // zero for odd ones in the triple, one for even
            assign group_o[g]   = ~^data15[3*g -: 3]; // [R14] [R15]
            assign group_n_o[g] = ~group_o[g];
        end
    endgenerate

    // odd data ones means the parity bit must be zero to keep odd total
    assign tree_o   = ^group_n_o; // [R16] [R11]
    assign tree_n_o = ~tree_o;    // [R16]
endmodule
`default_nettype wire

// ### verilog/madp_pkg.sv
// Contract
// [R01] x low line from address bits 1-3
// [R02] x high line from address bits 4-6
// [R03] y low line from address bits 7-8
// [R04] y high from bits 9-10 and bank
// [R05] y high 0-2 reach unswitched erasable
// [R06] y high 3-7 reach switched erasable
// [R07] switched window follows loaded bank, overlapping
// [R08] fixed selects 11-16 plus complements driven
// [R09] counter signals inhibited outside counter range
// [R10] five counter groups of eight locations
// [R11] stored words carry odd total parity
// [R12] parity bit generated for erasable writes
// [R13] checker uses bits 1-14 and 16
// [R14] fifteen data bits reduce to five groups
// [R15] group bit one when ones even
// [R16] groups feed tree with inverted copy
// [R17] read parity bit captured in flip-flop
// [R18] mismatch of flop and tree alarms
// [R19] write parity driven on own line
// [R20] address loads on control with write timing
// [R21] each select group exactly one line
// [R22] alarm only sampled during a readout
`default_nettype none
package madp_pkg;
    localparam int ADDR_W   = 12;
    localparam int WORD_W   = 16;
    localparam int EB_W     = 3;
    localparam int FB_W     = 5;
    localparam int FE_W     = 3;
    localparam int FSEL_W   = 6;
    localparam int GROUP_N  = 5;
    localparam int WB_ADR_W = 8;

    // address register field positions, bit 1 is the least significant
    localparam int XL_LSB  = 1;
    localparam int XL_MSB  = 3;
    localparam int XH_LSB  = 4;
    localparam int XH_MSB  = 6;
    localparam int YL_LSB  = 7;
    localparam int YL_MSB  = 8;
    localparam int YH_LSB  = 9;
    localparam int YH_MSB  = 10;
    localparam int REG_LSB = 11;
    localparam int REG_MSB = 12;
    localparam int PARITY_BIT = 15;

    localparam logic [1:0] YH_SWITCHED     = 2'h3;
    localparam logic [1:0] REGION_ERASABLE = 2'h0;
    localparam logic [1:0] REGION_FSWITCH  = 2'h1;
    localparam logic [1:0] REGION_FFIX2    = 2'h2;
    localparam logic [1:0] FB_EXT_SEL      = 2'h3;
    localparam logic [2:0] FE_SUPER        = 3'h4;
    localparam logic [5:0] FSEL_NONE       = 6'h00;
    localparam logic [5:0] FIXED_BANK_2    = 6'h02;
    localparam logic [5:0] FIXED_BANK_3    = 6'h03;
    localparam logic [2:0] GROUP_FIRST     = 3'h2;

    // register map, byte addresses
    localparam logic [7:0] OFS_ERASABLE_BANK_REG  = 8'h00;
    localparam logic [7:0] OFS_FIXED_BANK_REG  = 8'h04;
    localparam logic [7:0] OFS_FIXED_EXTENSION_REG   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam int ST_ALARM_BIT = 12;

    // reset values; selects reset to the decode of address zero
    localparam logic [11:0] ADDR_RST = 12'h000;
    localparam logic [2:0]  EB_RST   = 3'h0;
    localparam logic [4:0]  FB_RST   = 5'h00;
    localparam logic [2:0]  FE_RST   = 3'h0;
    localparam logic [7:0]  SEL8_RST = 8'h01;
    localparam logic [3:0]  SEL4_RST = 4'h1;
    localparam logic [4:0]  GRP_RST  = 5'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// ### verilog/madp_top.sv
// Decided for this implementation: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module madp_top (
    input  wire logic        CLK_I,                  // 10 MHz clock
    input  wire logic        SYS_RST_I,              // sync reset, high
    input  wire logic [7:0]  ADR_I,                  // wishbone byte address
    input  wire logic [31:0] DAT_I,                  // wishbone write data
    input  wire logic [3:0]  SEL_I,                  // wishbone byte enables
    input  wire logic        WE_I,                   // wishbone write
    input  wire logic        CYC_I,                  // wishbone cycle
    input  wire logic        STB_I,                  // wishbone strobe
    output logic      [31:0] DAT_O,                  // wishbone read data
    output logic             ACK_O,                  // wishbone acknowledge
    input  wire logic [16:1] WRITE_LINES_I,          // write lines
    input  wire logic        ADDRESS_WRITE_CONTROL_I, // address write control
    input  wire logic        WRITE_TIMING_I,         // write timing signal
    input  wire logic [16:1] READ_WORD_I,            // word read from memory
    input  wire logic        STORED_PARITY_BIT_I,    // parity bit from memory
    input  wire logic        READOUT_I,              // readout in progress
    input  wire logic [16:1] WRITE_WORD_I,           // word to erasable memory
    input  wire logic        ERASABLE_WRITE_I,       // erasable write strobe
    output logic      [7:0]  X_LOW_SELECT_O,         // x low select lines
    output logic      [7:0]  X_HIGH_SELECT_O,        // x high select lines
    output logic      [3:0]  Y_LOW_SELECT_O,         // y low select lines
    output logic      [7:0]  Y_HIGH_SELECT_O,        // y high select lines
    output logic      [5:0]  FIXED_SELECT_O,         // fixed selects 11..16
    output logic      [5:0]  FIXED_SELECT_N_O,       // complements
    output logic      [4:0]  COUNTER_GROUP_O,        // counter groups 2..6
    output logic             PARITY_ALARM_O,         // parity alarm pulse
    output logic             PARITY_WRITE_LINE_O,    // parity write line
    output logic      [12:1] ADDRESS_REG_O           // address register
);
    logic [12:1] addr_q;
    logic [12:1] addr_d;
    logic [2:0]  erasable_bank_reg_q;
    logic [4:0]  fixed_bank_reg_q;
    logic [2:0]  fixed_extension_reg_q;
    logic [7:0]  xl_q;
    logic [7:0]  xh_q;
    logic [3:0]  yl_q;
    logic [7:0]  yh_q;
    logic [5:0]  fsel_q;
    logic [5:0]  fsel_n_q;
    logic [4:0]  grp_q;
    logic [16:1] rword_q;
    logic        sap_q;
    logic        chk_q;
    logic        alarm_q;
    logic        alarm_d;
    logic        sticky_q;
    logic        sticky_d;
    logic        pwl_q;
    logic        pwl_d;
    logic        ack_q;
    logic [31:0] dat_q;

    // address register load
    logic        addr_load;
    logic [12:1] wl_addr;
    assign addr_load = ADDRESS_WRITE_CONTROL_I & WRITE_TIMING_I; // [R20]
    assign wl_addr   = WRITE_LINES_I[12:1];
    assign addr_d    = addr_load ? wl_addr : addr_q; // [R20]

    // address fields
    logic [2:0] xl_idx;
    logic [2:0] xh_idx;
    logic [1:0] yl_idx;
    logic [1:0] yh_field;
    logic [2:0] yh_idx;
    logic [1:0] region;
    assign xl_idx   = addr_q[madp_pkg::XL_MSB:madp_pkg::XL_LSB];   // [R01]
    assign xh_idx   = addr_q[madp_pkg::XH_MSB:madp_pkg::XH_LSB];   // [R02]
    assign yl_idx   = addr_q[madp_pkg::YL_MSB:madp_pkg::YL_LSB];   // [R03]
    assign yh_field = addr_q[madp_pkg::YH_MSB:madp_pkg::YH_LSB];
    assign region   = addr_q[madp_pkg::REG_MSB:madp_pkg::REG_LSB];

    // the top quarter of erasable space is the switched window; the
    // bank number picks the y high line, so banks 0..2 alias unswitched
    assign yh_idx = (yh_field == madp_pkg::YH_SWITCHED) ? erasable_bank_reg_q // [R04] [R06] [R07]
                                                        : {1'b0, yh_field}; // [R05]

    logic [7:0] xl_lines;
    logic [7:0] xh_lines;
    logic [3:0] yl_lines;
    logic [7:0] yh_lines;

    madp_onehot #(.IDX_W(3)) u_xl (
        .idx_i   (xl_idx),
        .lines_o (xl_lines)
    );
    madp_onehot #(.IDX_W(3)) u_xh (
        .idx_i   (xh_idx),
        .lines_o (xh_lines)
    );
    madp_onehot #(.IDX_W(2)) u_yl (
        .idx_i   (yl_idx),
        .lines_o (yl_lines)
    );
    madp_onehot #(.IDX_W(3)) u_yh (
        .idx_i   (yh_idx),
        .lines_o (yh_lines)
    );

    // fixed bank selection; erasable addresses drive no fixed select
    logic       fixed_extension_reg_hit;
    logic [5:0] fsel_d;
    assign fixed_extension_reg_hit = (fixed_bank_reg_q[4:3] == madp_pkg::FB_EXT_SEL) & (fixed_extension_reg_q >= madp_pkg::FE_SUPER);
    assign fsel_d = (region == madp_pkg::REGION_ERASABLE) ? madp_pkg::FSEL_NONE      // [R08]
                  : (region == madp_pkg::REGION_FSWITCH)  ? {fixed_extension_reg_hit, fixed_bank_reg_q}
                  : (region == madp_pkg::REGION_FFIX2)    ? madp_pkg::FIXED_BANK_2
                  :                                         madp_pkg::FIXED_BANK_3;

    // counter groups are decoded from the same selects the core sees
    logic       cnt_inhibit;
    logic [4:0] grp_d;
    assign cnt_inhibit = ~((region == madp_pkg::REGION_ERASABLE)
                           & yh_lines[0] & yl_lines[0]); // [R09]
    genvar g;
    generate
        for (g = 0; g < madp_pkg::GROUP_N; g++) begin : g_cnt
            assign grp_d[g] = ~cnt_inhibit & xh_lines[int'(madp_pkg::GROUP_FIRST) + g]; // [R10]
        end
    endgenerate

    // parity check on readout and generation on write
    logic        rd_tree;
    logic        rd_tree_n;
    logic        wr_tree_n;
    logic [15:1] rd_data15;
    logic [15:1] wr_data15;
    assign rd_data15 = {READ_WORD_I[16], READ_WORD_I[14:1]};
    assign wr_data15 = {WRITE_WORD_I[16], WRITE_WORD_I[14:1]};

    madp_parity u_rd_par (
        .word_i    (rword_q),
        .group_o   (),
        .group_n_o (),
        .tree_o    (rd_tree),
        .tree_n_o  (rd_tree_n)
    );
    madp_parity u_wr_par (
        .word_i    (WRITE_WORD_I),
        .group_o   (),
        .group_n_o (),
        .tree_o    (),
        .tree_n_o  (wr_tree_n)
    );

    // set output of the flop meets the tree, reset output its inverse
    assign alarm_d = chk_q & ((sap_q & rd_tree) | (~sap_q & rd_tree_n)); // [R18] [R22]
    // parity line holds its value between writes
    assign pwl_d   = ERASABLE_WRITE_I ? wr_tree_n : pwl_q; // [R12] [R19]

    // wishbone decode; one wait state, ack is dropped after one cycle
    logic        wb_req;
    logic        wb_wr;
    logic        hit_eb;
    logic        hit_fb;
    logic        hit_fe;
    logic        hit_st;
    logic        alarm_clr;
    logic [31:0] status_w;
    logic [31:0] rd_mux;
    assign wb_req = CYC_I & STB_I & ~ack_q;
    assign wb_wr  = wb_req & WE_I;
    assign hit_eb = (ADR_I == madp_pkg::OFS_ERASABLE_BANK_REG);
    assign hit_fb = (ADR_I == madp_pkg::OFS_FIXED_BANK_REG);
    assign hit_fe = (ADR_I == madp_pkg::OFS_FIXED_EXTENSION_REG);
    assign hit_st = (ADR_I == madp_pkg::OFS_STATUS);
    assign alarm_clr = wb_wr & hit_st & SEL_I[1] & DAT_I[madp_pkg::ST_ALARM_BIT];
    // a new alarm in the clearing cycle survives
    assign sticky_d  = alarm_d | (sticky_q & ~alarm_clr);
    assign status_w  = {18'h00000, pwl_q, sticky_q, addr_q};
    assign rd_mux = hit_eb ? 32'(erasable_bank_reg_q)
                  : hit_fb ? 32'(fixed_bank_reg_q)
                  : hit_fe ? 32'(fixed_extension_reg_q)
                  : hit_st ? status_w
                  :          madp_pkg::WORD_ZERO;

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            erasable_bank_reg_q <= madp_pkg::EB_RST;
            fixed_bank_reg_q <= madp_pkg::FB_RST;
            fixed_extension_reg_q  <= madp_pkg::FE_RST;
        end else if (wb_wr & SEL_I[0]) begin
            if (hit_eb) begin
                erasable_bank_reg_q <= DAT_I[2:0];
            end
            if (hit_fb) begin
                fixed_bank_reg_q <= DAT_I[4:0];
            end
            if (hit_fe) begin
                fixed_extension_reg_q <= DAT_I[2:0];
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            ack_q <= 1'b0;
            dat_q <= madp_pkg::WORD_ZERO;
        end else begin
            ack_q <= wb_req;
            dat_q <= (wb_req & ~WE_I) ? rd_mux : madp_pkg::WORD_ZERO;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            addr_q   <= madp_pkg::ADDR_RST;
            xl_q     <= madp_pkg::SEL8_RST;
            xh_q     <= madp_pkg::SEL8_RST;
            yl_q     <= madp_pkg::SEL4_RST;
            yh_q     <= madp_pkg::SEL8_RST;
            fsel_q   <= madp_pkg::FSEL_NONE;
            fsel_n_q <= ~madp_pkg::FSEL_NONE;
            grp_q    <= madp_pkg::GRP_RST;
        end else begin
            addr_q   <= addr_d;
            xl_q     <= xl_lines; // [R01]
            xh_q     <= xh_lines; // [R02]
            yl_q     <= yl_lines; // [R03]
            yh_q     <= yh_lines; // [R04]
            fsel_q   <= fsel_d;   // [R08]
            fsel_n_q <= ~fsel_d;  // [R08]
            grp_q    <= grp_d;    // [R10]
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            rword_q  <= '0;
            sap_q    <= 1'b0;
            chk_q    <= 1'b0;
            alarm_q  <= 1'b0;
            sticky_q <= 1'b0;
            pwl_q    <= 1'b0;
        end else begin
            if (READOUT_I) begin
                rword_q <= READ_WORD_I;
            end
            // flop is set by a one, otherwise left reset
            sap_q    <= READOUT_I & STORED_PARITY_BIT_I; // [R17]
            chk_q    <= READOUT_I;                       // [R22]
            alarm_q  <= alarm_d;                         // [R18]
            sticky_q <= sticky_d;
            pwl_q    <= pwl_d;                           // [R19]
        end
    end

    assign DAT_O               = dat_q;
    assign ACK_O               = ack_q;
    assign X_LOW_SELECT_O      = xl_q;
    assign X_HIGH_SELECT_O     = xh_q;
    assign Y_LOW_SELECT_O      = yl_q;
    assign Y_HIGH_SELECT_O     = yh_q;
    assign FIXED_SELECT_O      = fsel_q;
    assign FIXED_SELECT_N_O    = fsel_n_q;
    assign COUNTER_GROUP_O     = grp_q;
    assign PARITY_ALARM_O      = alarm_q;
    assign PARITY_WRITE_LINE_O = pwl_q;
    assign ADDRESS_REG_O       = addr_q;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    AST_X_LOW: assert property ( // [R01]
        1'b1 |=> X_LOW_SELECT_O == (madp_pkg::SEL8_RST << $past(xl_idx)))
        else $error("x low select does not follow address bits 1-3");

    AST_X_HIGH: assert property ( // [R02]
        1'b1 |=> X_HIGH_SELECT_O == (madp_pkg::SEL8_RST << $past(xh_idx)))
        else $error("x high select does not follow address bits 4-6");

    AST_Y_LOW: assert property ( // [R03]
        1'b1 |=> Y_LOW_SELECT_O == (madp_pkg::SEL4_RST << $past(yl_idx)))
        else $error("y low select does not follow address bits 7-8");

    AST_Y_HIGH_SW: assert property ( // [R07]
        (yh_field == madp_pkg::YH_SWITCHED)
        |=> Y_HIGH_SELECT_O == (madp_pkg::SEL8_RST << $past(erasable_bank_reg_q)))
        else $error("switched y high select does not follow bank");

    AST_Y_HIGH_UNSW: assert property ( // [R05]
        (yh_field != madp_pkg::YH_SWITCHED) |=> (Y_HIGH_SELECT_O[7:3] == 5'h00))
        else $error("unswitched address reached a switched y high line");

    AST_ONE_LINE: assert property ( // [R21]
        $onehot(X_LOW_SELECT_O) && $onehot(X_HIGH_SELECT_O)
        && $onehot(Y_LOW_SELECT_O) && $onehot(Y_HIGH_SELECT_O))
        else $error("a select group does not have exactly one line");

    AST_FIXED: assert property ( // [R08]
        (region == madp_pkg::REGION_ERASABLE)
        |=> (FIXED_SELECT_O == madp_pkg::FSEL_NONE) && (FIXED_SELECT_N_O == ~FIXED_SELECT_O))
        else $error("fixed selects wrong for an erasable address");

    AST_FIXED_N: assert property ( // [R08]
        FIXED_SELECT_N_O == ~FIXED_SELECT_O)
        else $error("fixed select complements do not match");

    AST_Y_HIGH_BANK: assert property ( // [R06]
        (yh_field == madp_pkg::YH_SWITCHED) && (erasable_bank_reg_q >= 3'h3)
        |=> (Y_HIGH_SELECT_O[2:0] == 3'h0))
        else $error("switched bank reached an unswitched y high line");

    AST_PWL_HOLD: assert property ( // [R19]
        !ERASABLE_WRITE_I |=> $stable(PARITY_WRITE_LINE_O))
        else $error("parity write line changed without a write");

    AST_CNT_INH: assert property ( // [R09]
        cnt_inhibit |=> (COUNTER_GROUP_O == madp_pkg::GRP_RST))
        else $error("counter group raised outside counter range");

    AST_CNT_GRP4: assert property ( // [R10]
        (!cnt_inhibit && xh_idx == 3'h4) |=> (COUNTER_GROUP_O == 5'h04))
        else $error("locations 0040-0047 did not raise group 4");

    AST_LOAD: assert property ( // [R20]
        addr_load |=> (ADDRESS_REG_O == $past(wl_addr)))
        else $error("address register missed a load");

    AST_HOLD: assert property ( // [R20]
        !addr_load |=> $stable(ADDRESS_REG_O))
        else $error("address register changed without a load");

    AST_WR_PARITY: assert property ( // [R12]
        ERASABLE_WRITE_I |=> (^{$past(wr_data15), PARITY_WRITE_LINE_O} == 1'b1))
        else $error("written word plus parity bit is not odd");

    AST_ALARM: assert property ( // [R18]
        READOUT_I |-> ##2
        (PARITY_ALARM_O == !(^{$past(rd_data15, 2), $past(STORED_PARITY_BIT_I, 2)})))
        else $error("parity alarm disagrees with word read");

    AST_IDLE: assert property ( // [R22]
        PARITY_ALARM_O |-> $past(READOUT_I, 2))
        else $error("parity alarm raised without a readout");

    COV_ALARM: cover property (READOUT_I ##2 PARITY_ALARM_O);
    COV_SWITCHED: cover property ((yh_field == madp_pkg::YH_SWITCHED) && erasable_bank_reg_q == 3'h5);
    COV_COUNTER: cover property (COUNTER_GROUP_O != madp_pkg::GRP_RST);
    COV_WB_WRITE: cover property (wb_wr && hit_eb ##1 ACK_O);
    COV_FIXED_EXT: cover property (FIXED_SELECT_O[5]);
endmodule
`default_nettype wire
